// [iras_pkg.sv]
// Shared constants and types for the two-wire register access link
package iras_pkg;

  localparam logic [6:0] DEV_ADDR = 7'h1D;
  localparam logic [7:0] FIRST_RD = 8'h3B;
  localparam logic [7:0] FIRST_WR = 8'h3A;
  localparam logic [7:0] BYTE_IDLE = 8'hFF;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE  = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE  = 8'h01;
  localparam logic [1:0] STEP_0 = 2'h0;
  localparam logic [1:0] STEP_1 = 2'h1;
  localparam logic [1:0] STEP_2 = 2'h2;

  // Core clock and bus clock rates
  localparam int CLK_HZ  = 50000000;
  localparam int FAST_HZ = 400000;
  localparam int STD_HZ  = 100000;
  localparam int CLK_NS  = 1000000000 / CLK_HZ;
  localparam int SCL_NS  = 1000000000 / FAST_HZ;
  localparam int HALF_INT = (SCL_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] HALF_CYC = 8'(HALF_INT);

  typedef enum logic [6:0] {
    D_IDLE  = 7'h01,
    D_RX    = 7'h02,
    D_ACK   = 7'h04,
    D_STALL = 7'h08,
    D_TX    = 7'h10,
    D_TXACK = 7'h20,
    D_WAIT  = 7'h40
  } iras_dstate_t;

  typedef enum logic [2:0] {
    K_ADDR = 3'h1,
    K_REG  = 3'h2,
    K_DATA = 3'h4
  } iras_kind_t;

  typedef enum logic [6:0] {
    H_IDLE   = 7'h01,
    H_START  = 7'h02,
    H_FETCH  = 7'h04,
    H_LOW    = 7'h08,
    H_HIGH   = 7'h10,
    H_RSTART = 7'h20,
    H_STOP   = 7'h40
  } iras_hstate_t;

  typedef enum logic [3:0] {
    S_AW   = 4'h1,
    S_REG  = 4'h2,
    S_AR   = 4'h4,
    S_DATA = 4'h8
  } iras_stage_t;

endpackage : iras_pkg

// [iras_if.sv]
// Open-drain two-wire bus joining the host end and the device end
`timescale 1ns/1ps
interface iras_if;
  logic scl_i;
  logic sda_i;
  logic h_scl_o;
  logic h_scl_oe_n;
  logic h_sda_o;
  logic h_sda_oe_n;
  logic d_scl_o;
  logic d_scl_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;

  // Wired AND with pull-ups: high unless someone pulls low
  assign scl_i = !((!h_scl_oe_n && !h_scl_o) || (!d_scl_oe_n && !d_scl_o));
  assign sda_i = !((!h_sda_oe_n && !h_sda_o) || (!d_sda_oe_n && !d_sda_o));

  modport dev (
    input  scl_i,
    input  sda_i,
    output d_scl_o,
    output d_scl_oe_n,
    output d_sda_o,
    output d_sda_oe_n
  );

  modport host (
    input  scl_i,
    input  sda_i,
    output h_scl_o,
    output h_scl_oe_n,
    output h_sda_o,
    output h_sda_oe_n
  );
endinterface : iras_if

// [iras_host.sv]
// Bus master end: runs register read and write transfers
`timescale 1ns/1ps
module iras_host
  import iras_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  iras_if.host            bus,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_rd,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [7:0] cmd_len,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            done,
  output logic            nack_err
);

  // Builds the nine-bit frame of the next byte, ack slot last
  function automatic logic [8:0] frame(iras_stage_t st, logic rd,
                                       logic [7:0] rg, logic last);
    frame = {BYTE_IDLE, last};
    if (st == S_AW) frame = {FIRST_WR, 1'h1};
    if (st == S_REG) frame = {rg, 1'h1};
    if (st == S_AR) frame = {FIRST_RD, 1'h1};
    if (st == S_DATA && !rd) frame = {BYTE_IDLE, 1'h1};
  endfunction : frame

  ////////////////////////////////////////////////////////////////////////
  logic [1:0]   scl_sy;
  logic [1:0]   sda_sy;
  iras_hstate_t state;
  iras_stage_t  stage;
  logic [7:0]   cnt;
  logic [1:0]   step;
  logic [3:0]   bitcnt;
  logic [8:0]   txw;
  logic [7:0]   rxw;
  logic [7:0]   len_left;
  logic [7:0]   reg_sel;
  logic         rd_mode;
  logic         scl_oe_n;
  logic         sda_oe_n;

  wire scl_s     = scl_sy[1];
  wire sda_s     = sda_sy[1];
  wire half_done = (cnt == HALF_CYC);
  wire last_byte = (len_left == CNT_ONE);
  wire [7:0] cnt_inc = 8'(cnt + CNT_ONE);

  assign bus.h_scl_o    = 1'h0;
  assign bus.h_sda_o    = 1'h0;
  assign bus.h_scl_oe_n = scl_oe_n;
  assign bus.h_sda_oe_n = sda_oe_n;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
    end else begin
      scl_sy <= {scl_sy[0], bus.scl_i};
      sda_sy <= {sda_sy[0], bus.sda_i};
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state     <= H_IDLE;
      stage     <= S_AW;
      cnt       <= CNT_ZERO;
      step      <= STEP_0;
      bitcnt    <= BIT_ZERO;
      txw       <= 9'h1FF;
      rxw       <= 8'h00;
      len_left  <= CNT_ZERO;
      reg_sel   <= 8'h00;
      rd_mode   <= 1'h0;
      scl_oe_n  <= 1'h1;
      sda_oe_n  <= 1'h1;
      cmd_ready <= 1'h1;
      tx_ready  <= 1'h0;
      rx_valid  <= 1'h0;
      rx_data   <= 8'h00;
      done      <= 1'h0;
      nack_err  <= 1'h0;
    end else begin
      rx_valid <= 1'h0;
      done     <= 1'h0;
      case (state)
        H_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'h0;
            nack_err  <= 1'h0;
            rd_mode   <= cmd_rd;
            reg_sel   <= cmd_reg;
            len_left  <= cmd_len;
            cnt       <= CNT_ZERO;
            state     <= H_START;
          end
        end
        H_START: begin
          sda_oe_n <= 1'h0;
          cnt      <= cnt_inc;
          if (half_done) begin
            scl_oe_n <= 1'h0;
            stage    <= S_AW;
            txw      <= frame(S_AW, rd_mode, reg_sel, 1'h1);
            bitcnt   <= BIT_ZERO;
            cnt      <= CNT_ZERO;
            state    <= H_LOW;
          end
        end
        H_FETCH: begin
          tx_ready <= 1'h1;
          if (tx_valid && tx_ready) begin
            tx_ready <= 1'h0;
            txw      <= {tx_data, 1'h1};
            bitcnt   <= BIT_ZERO;
            cnt      <= CNT_ZERO;
            state    <= H_LOW;
          end
        end
        H_LOW: begin
          if (cnt == CNT_ZERO) sda_oe_n <= txw[8];
          cnt <= cnt_inc;
          if (half_done) begin
            scl_oe_n <= 1'h1;
            cnt      <= CNT_ZERO;
            state    <= H_HIGH;
          end
        end
        H_HIGH: begin
          // Waits out a device that holds the clock low
          if (scl_s) cnt <= cnt_inc;
          if (half_done) begin
            scl_oe_n <= 1'h0;
            cnt      <= CNT_ZERO;
            txw      <= {txw[7:0], 1'h1};
            bitcnt   <= 4'(bitcnt + BIT_ONE);
            state    <= H_LOW;
            if (bitcnt != BIT_LAST) rxw <= {rxw[6:0], sda_s};
            if (bitcnt == BIT_LAST) begin
              bitcnt <= BIT_ZERO;
              if (stage != S_DATA || !rd_mode) begin
                if (sda_s) begin
                  nack_err <= 1'h1;
                  step     <= STEP_0;
                  state    <= H_STOP;
                end else if (stage == S_AW) begin
                  stage <= S_REG;
                  txw   <= frame(S_REG, rd_mode, reg_sel, 1'h1);
                end else if (stage == S_REG && rd_mode) begin
                  step  <= STEP_0;
                  state <= H_RSTART;
                end else if (stage == S_AR) begin
                  stage <= S_DATA;
                  txw   <= frame(S_DATA, rd_mode, reg_sel, last_byte);
                end else if (stage == S_REG) begin
                  stage <= S_DATA;
                  state <= H_FETCH;
                end else if (last_byte) begin
                  step  <= STEP_0;
                  state <= H_STOP;
                end else begin
                  len_left <= 8'(len_left - CNT_ONE);
                  state    <= H_FETCH;
                end
              end else begin
                rx_valid <= 1'h1;
                rx_data  <= rxw;
                len_left <= 8'(len_left - CNT_ONE);
                txw      <= frame(S_DATA, rd_mode, reg_sel, len_left == 8'h02);
                if (last_byte) begin
                  step  <= STEP_0;
                  state <= H_STOP;
                end
              end
            end
          end
        end
        H_RSTART: begin
          cnt <= cnt_inc;
          if (step == STEP_0) sda_oe_n <= 1'h1;
          if (step == STEP_1) scl_oe_n <= 1'h1;
          if (step == STEP_2) sda_oe_n <= 1'h0;
          if (half_done) begin
            cnt  <= CNT_ZERO;
            step <= 2'(step + STEP_1);
            if (step == STEP_2) begin
              scl_oe_n <= 1'h0;
              stage    <= S_AR;
              txw      <= frame(S_AR, rd_mode, reg_sel, 1'h1);
              state    <= H_LOW;
            end
          end
        end
        H_STOP: begin
          cnt <= cnt_inc;
          if (step == STEP_0) sda_oe_n <= 1'h0;
          if (step == STEP_1) scl_oe_n <= 1'h1;
          if (step == STEP_2) sda_oe_n <= 1'h1;
          if (half_done) begin
            cnt  <= CNT_ZERO;
            step <= 2'(step + STEP_1);
            if (step == STEP_2) begin
              done      <= 1'h1;
              cmd_ready <= 1'h1;
              state     <= H_IDLE;
            end
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

endmodule : iras_host

// [iras_dev.sv]
// Device end: two-wire slave giving access to the register map
//
// Functional notes
// - Ignore the bus without core supply
// - Work at standard and fast bus rates
// - Start: data falls while clock high
// - First byte: seven address bits, direction
// - Selected only on exact address match
// - Receiver pulls ninth-clock acknowledge low
// - Stop: data rises while clock high
// - Answer the fixed seven-bit address
// - Returned bytes go out MSB first
// - Data changes only after clock falls
// - Read: write address, register, restart, read
// - Ack address and register, keep across restart
// - Master ends read with no-ack, stop
// - Master ack advances to next register
// - Ack and store each written byte
// - Advance register address after each write
// - Never drive lines when not selected
// - Lines only pulled low or released
`timescale 1ns/1ps
module iras_dev
  import iras_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  iras_if.dev             bus,
  input  wire logic       core_supply_ok,
  output logic [7:0]      reg_addr,
  input  wire logic [7:0] reg_rdata,
  input  wire logic [7:0] reg_next_addr,
  output logic            reg_rd,
  output logic            wr_valid,
  input  wire logic       wr_ready,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic            selected
);

  function automatic logic [3:0] bit_inc(logic [3:0] v);
    bit_inc = 4'(v + BIT_ONE);
  endfunction : bit_inc

  ////////////////////////////////////////////////////////////////////////
  // Line synchronisers and condition detection
  logic [1:0]   scl_sy;
  logic [1:0]   sda_sy;
  logic [1:0]   pwr_sy;
  logic         scl_p;
  logic         sda_p;

  iras_dstate_t state;
  iras_kind_t   kind;
  logic [3:0]   bitcnt;
  logic [7:0]   shreg;
  logic         dir_rd;
  logic         scl_oe_n;
  logic         sda_oe_n;

  logic         skid_v;
  logic [7:0]   skid_addr;
  logic [7:0]   skid_data;

  wire scl_s     = scl_sy[1];
  wire sda_s     = sda_sy[1];
  wire powered   = pwr_sy[1];
  wire scl_rise  = scl_s && !scl_p;
  wire scl_fall  = !scl_s && scl_p;
  wire bus_start = scl_s && scl_p && sda_p && !sda_s;
  wire bus_stop  = scl_s && scl_p && !sda_p && sda_s;
  wire byte_done = scl_fall && (bitcnt == BIT_LAST);
  wire addr_hit  = (shreg[7:1] == DEV_ADDR);
  wire in_ready  = !skid_v;
  wire data_byte = (state == D_RX) && byte_done && (kind == K_DATA);
  wire push      = (data_byte || state == D_STALL) && in_ready;
  wire pop       = wr_valid && wr_ready;

  // Open-drain: outputs stay low, only enables move
  assign bus.d_scl_o    = 1'h0;
  assign bus.d_sda_o    = 1'h0;
  assign bus.d_scl_oe_n = scl_oe_n;
  assign bus.d_sda_oe_n = sda_oe_n;

  // Sampling at 50 MHz covers both bus rates
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      pwr_sy <= 2'h0;
      scl_p  <= 1'h1;
      sda_p  <= 1'h1;
    end else begin
      scl_sy <= {scl_sy[0], bus.scl_i};
      sda_sy <= {sda_sy[0], bus.sda_i};
      pwr_sy <= {pwr_sy[0], core_supply_ok};
      scl_p  <= scl_s;
      sda_p  <= sda_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Protocol engine
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state    <= D_IDLE;
      kind     <= K_ADDR;
      bitcnt   <= BIT_ZERO;
      shreg    <= 8'h00;
      dir_rd   <= 1'h0;
      scl_oe_n <= 1'h1;
      sda_oe_n <= 1'h1;
      reg_addr <= 8'h00;
      reg_rd   <= 1'h0;
      selected <= 1'h0;
    end else begin
      reg_rd <= 1'h0;
      if (!powered || bus_stop) begin
        // Off state or end of transfer: release everything
        state    <= D_IDLE;
        scl_oe_n <= 1'h1;
        sda_oe_n <= 1'h1;
        selected <= 1'h0;
      end else if (bus_start) begin
        // Start or repeated start; register address is kept
        state    <= D_RX;
        kind     <= K_ADDR;
        bitcnt   <= BIT_ZERO;
        scl_oe_n <= 1'h1;
        sda_oe_n <= 1'h1;
        selected <= 1'h0;
      end else begin
        case (state)
          D_RX: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], sda_s};
              bitcnt <= bit_inc(bitcnt);
            end
            if (byte_done) begin
              if (kind == K_ADDR) begin
                if (addr_hit) begin
                  dir_rd   <= shreg[0];
                  selected <= 1'h1;
                  sda_oe_n <= 1'h0;
                  state    <= D_ACK;
                end else begin
                  state <= D_WAIT;
                end
              end else if (kind == K_REG) begin
                reg_addr <= shreg;
                sda_oe_n <= 1'h0;
                state    <= D_ACK;
              end else if (in_ready) begin
                reg_addr <= reg_next_addr;
                sda_oe_n <= 1'h0;
                state    <= D_ACK;
              end else begin
                // Buffer full: hold the clock low until room
                scl_oe_n <= 1'h0;
                state    <= D_STALL;
              end
            end
          end
          D_STALL: begin
            if (in_ready) begin
              reg_addr <= reg_next_addr;
              sda_oe_n <= 1'h0;
              state    <= D_ACK;
            end
          end
          D_ACK: begin
            scl_oe_n <= 1'h1;
            if (scl_fall) begin
              sda_oe_n <= 1'h1;
              bitcnt   <= BIT_ZERO;
              if (kind == K_ADDR && dir_rd) begin
                shreg    <= reg_rdata;
                sda_oe_n <= reg_rdata[7];
                reg_rd   <= 1'h1;
                state    <= D_TX;
              end else begin
                kind  <= (kind == K_ADDR) ? K_REG : K_DATA;
                state <= D_RX;
              end
            end
          end
          D_TX: begin
            if (scl_rise) bitcnt <= bit_inc(bitcnt);
            if (scl_fall) begin
              if (bitcnt == BIT_LAST) begin
                sda_oe_n <= 1'h1;
                state    <= D_TXACK;
              end else begin
                shreg    <= {shreg[6:0], 1'h0};
                sda_oe_n <= shreg[6];
              end
            end
          end
          D_TXACK: begin
            if (scl_rise) begin
              if (!sda_s) begin
                reg_addr <= reg_next_addr;
              end else begin
                selected <= 1'h0;
                state    <= D_WAIT;
              end
            end
            if (scl_fall) begin
              shreg    <= reg_rdata;
              sda_oe_n <= reg_rdata[7];
              bitcnt   <= BIT_ZERO;
              reg_rd   <= 1'h1;
              state    <= D_TX;
            end
          end
          D_WAIT: begin
            sda_oe_n <= 1'h1;
            scl_oe_n <= 1'h1;
          end
          D_IDLE: begin
            sda_oe_n <= 1'h1;
          end
          default: state <= D_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two-entry write buffer: output stage plus skid stage
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_valid  <= 1'h0;
      wr_addr   <= 8'h00;
      wr_data   <= 8'h00;
      skid_v    <= 1'h0;
      skid_addr <= 8'h00;
      skid_data <= 8'h00;
    end else if (pop || !wr_valid) begin
      if (skid_v) begin
        wr_valid <= 1'h1;
        wr_addr  <= skid_addr;
        wr_data  <= skid_data;
        skid_v   <= 1'h0;
      end else begin
        wr_valid <= push;
        wr_addr  <= reg_addr;
        wr_data  <= shreg;
      end
    end else if (push) begin
      skid_v    <= 1'h1;
      skid_addr <= reg_addr;
      skid_data <= shreg;
    end
  end

endmodule : iras_dev

// [iras_monitor.sv]
// Bus checker for the two-wire link between host and device ends
`timescale 1ns/1ps
module iras_monitor (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic h_scl_o,
  input wire logic h_scl_oe_n,
  input wire logic h_sda_o,
  input wire logic h_sda_oe_n,
  input wire logic d_scl_o,
  input wire logic d_scl_oe_n,
  input wire logic d_sda_o,
  input wire logic d_sda_oe_n
);
  localparam int LOW_MIN = 60;
  int low_cnt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Length of the current clock low phase
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) low_cnt <= 0;
    else if (scl_i) low_cnt <= 0;
    else if (low_cnt < 1000) low_cnt <= low_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_DEV_OPEN_DRAIN: assert property (!d_scl_o && !d_sda_o)
    else $error("device drives a line high");
  AST_HOST_OPEN_DRAIN: assert property (!h_scl_o && !h_sda_o)
    else $error("host drives a line high");
  AST_DEV_SDA_IN_LOW: assert property ($changed(d_sda_oe_n) |-> !scl_i && !$past(scl_i))
    else $error("device data changed outside clock low");
  AST_START_CLOCKS: assert property ($fell(sda_i) && scl_i |-> ##[1:100] !scl_i)
    else $error("no clock after start");
  AST_SCL_LOW_MIN: assert property ($rose(scl_i) |-> low_cnt >= LOW_MIN)
    else $error("clock low phase too short");
  AST_STRETCH_BOUND: assert property ($fell(d_scl_oe_n) |-> ##[1:1000] d_scl_oe_n)
    else $error("clock stretch not released");
  AST_STRETCH_IN_LOW: assert property ($fell(d_scl_oe_n) |-> !$past(scl_i))
    else $error("device pulled clock during high phase");
  AST_IDLE_AFTER_STOP: assert property (
    $rose(sda_i) && scl_i && $past(scl_i) |-> (d_sda_oe_n && d_scl_oe_n) [*4])
    else $error("device drives after stop");

  COV_STRETCH: cover property ($fell(d_scl_oe_n));
  COV_DEV_ACK: cover property ($rose(scl_i) && !d_sda_oe_n);
  COV_STOP: cover property ($rose(sda_i) && scl_i);
endmodule : iras_monitor

// [testbench.sv]
// Self-checking bench: host end and device end joined over the two-wire bus
`timescale 1ns/1ps
module testbench
  import iras_pkg::*;
;
  logic       core_clk, rstn, core_supply_ok, wr_ready, cmd_valid, cmd_rd, tx_valid;
  logic [7:0] cmd_reg, cmd_len, tx_data, reg_addr, wr_addr, wr_data, rx_data;
  logic       cmd_ready, tx_ready, rx_valid, done, nack_err, reg_rd, wr_valid, selected;
  logic [7:0] mem [256];
  logic [7:0] dat [3] = '{8'h5A, 8'hC3, 8'h81};
  logic [7:0] tx_q[$], rx_q[$];
  logic [8:0] wire_q[$], exp_q[$];
  logic [8:0] sh;
  logic       scl_q, sda_q, stretched, sel_seen;
  int         nbit, n_rd, n_fail, tests_run;

  iras_if bus ();
  iras_host iras_host_inst (.core_clk(core_clk), .rstn(rstn), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_rd(cmd_rd), .cmd_reg(cmd_reg),
    .cmd_len(cmd_len), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_data(rx_data), .done(done), .nack_err(nack_err));
  iras_dev iras_dev_inst (.core_clk(core_clk), .rstn(rstn), .bus(bus),
    .core_supply_ok(core_supply_ok), .reg_addr(reg_addr), .reg_rdata(mem[reg_addr]),
    .reg_next_addr(reg_addr + 8'h01), .reg_rd(reg_rd), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .selected(selected));
  iras_monitor iras_monitor_inst (.core_clk(core_clk), .rstn(rstn), .scl_i(bus.scl_i),
    .sda_i(bus.sda_i), .h_scl_o(bus.h_scl_o), .h_scl_oe_n(bus.h_scl_oe_n),
    .h_sda_o(bus.h_sda_o), .h_sda_oe_n(bus.h_sda_oe_n), .d_scl_o(bus.d_scl_o),
    .d_scl_oe_n(bus.d_scl_oe_n), .d_sda_o(bus.d_sda_o), .d_sda_oe_n(bus.d_sda_oe_n));

  always #10 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, write data feed, read capture, wire sniffer
  always @(posedge core_clk) begin
    if (wr_valid && wr_ready) mem[wr_addr] <= wr_data;
    if (tx_valid && tx_ready) void'(tx_q.pop_front());
    if (rx_valid === 1'b1) rx_q.push_back(rx_data);
    if (reg_rd === 1'b1) n_rd++;
    if (selected === 1'b1) sel_seen = 1'b1;
    if (scl_q && bus.scl_i && sda_q && !bus.sda_i) nbit = 0;
    else if (!scl_q && bus.scl_i) begin
      sh = {sh[7:0], bus.sda_i};
      nbit++;
      if (nbit == 9) begin
        wire_q.push_back(sh);
        nbit = 0;
      end
    end
    scl_q = bus.scl_i;
    sda_q = bus.sda_i;
  end

  always @(negedge core_clk) begin
    tx_valid <= tx_q.size() != 0;
    if (tx_q.size() != 0) tx_data <= tx_q[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] fr(input logic [7:0] b, input logic a);
    return {b, a};
  endfunction : fr

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_wire();
    chk(9'(wire_q.size()), 9'(exp_q.size()));
    foreach (exp_q[k]) if (k < wire_q.size()) chk(wire_q[k], exp_q[k]);
  endtask : chk_wire

  task automatic run_cmd(input logic rd, input logic [7:0] r, input logic [7:0] len);
    int i;
    wire_q.delete();
    rx_q.delete();
    n_rd = 0;
    sel_seen = 1'b0;
    @(negedge core_clk);
    chk({8'h00, cmd_ready}, 9'h001);
    cmd_valid = 1'b1;
    cmd_rd = rd;
    cmd_reg = r;
    cmd_len = len;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    i = 0;
    while (done !== 1'b1 && i < 40000) begin
      @(negedge core_clk);
      i++;
    end
    chk({8'h00, i < 40000}, 9'h001);
    @(negedge core_clk);
    chk({7'h00, bus.scl_i, bus.sda_i}, 9'h003);
    chk({8'h00, selected}, 9'h000);
  endtask : run_cmd

  task automatic report_and_stop();
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0; rstn = 1'b0; core_supply_ok = 1'b1; wr_ready = 1'b0;
    cmd_valid = 1'b0; cmd_rd = 1'b0; cmd_reg = 8'h00; cmd_len = 8'h00;
    tx_valid = 1'b0; tx_data = 8'h00; scl_q = 1'b1; sda_q = 1'b1; sh = 9'h000;
    nbit = 0; n_rd = 0; n_fail = 0; tests_run = 0; stretched = 1'b0; sel_seen = 1'b0;
    foreach (mem[k]) mem[k] = 8'h00;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk) rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    // Burst write with the map stalled until 200 cycles after the device stretches
    tx_q = '{dat[0], dat[1], dat[2]};
    fork
      run_cmd(1'b0, 8'h10, 8'h03);
      begin
        for (int k = 0; k < 20000 && bus.d_scl_oe_n !== 1'b0; k++) @(negedge core_clk);
        stretched = (bus.d_scl_oe_n === 1'b0);
        repeat (200) @(negedge core_clk);
        wr_ready = 1'b1;
      end
    join
    exp_q = '{fr(FIRST_WR, 0), fr(8'h10, 0), fr(dat[0], 0), fr(dat[1], 0), fr(dat[2], 0)};
    chk_wire();
    chk({8'h00, stretched}, 9'h001);
    for (int k = 0; k < 3; k++) chk({1'b0, mem[8'h10 + k]}, {1'b0, dat[k]});
    chk({8'h00, nack_err}, 9'h000);
    chk({8'h00, sel_seen}, 9'h001);
    chk({1'b0, reg_addr}, 9'h013);
    // Burst read back from the same place
    run_cmd(1'b1, 8'h10, 8'h03);
    exp_q = '{fr(FIRST_WR, 0), fr(8'h10, 0), fr(FIRST_RD, 0), fr(dat[0], 0),
              fr(dat[1], 0), fr(dat[2], 1)};
    chk_wire();
    chk(9'(rx_q.size()), 9'h003);
    for (int k = 0; k < 3; k++) chk({1'b0, rx_q[k]}, {1'b0, dat[k]});
    chk(9'(n_rd), 9'h003);
    chk({1'b0, reg_addr}, 9'h012);
    // Single write at the top address, single read right after
    tx_q = '{8'h66};
    run_cmd(1'b0, 8'hFF, 8'h01);
    chk({1'b0, mem[8'hFF]}, 9'h066);
    run_cmd(1'b1, 8'hFF, 8'h01);
    exp_q = '{fr(FIRST_WR, 0), fr(8'hFF, 0), fr(FIRST_RD, 0), fr(8'h66, 1)};
    chk_wire();
    // Core supply off: address not answered, nothing stored
    core_supply_ok = 1'b0;
    repeat (4) @(negedge core_clk);
    tx_q = '{8'h99};
    run_cmd(1'b0, 8'h20, 8'h01);
    exp_q = '{fr(FIRST_WR, 1)};
    chk_wire();
    chk({8'h00, nack_err}, 9'h001);
    chk({1'b0, mem[8'h20]}, 9'h000);
    chk({8'h00, sel_seen}, 9'h000);
    tx_q.delete();
    core_supply_ok = 1'b1;
    repeat (4) @(negedge core_clk);
    run_cmd(1'b1, 8'h12, 8'h01);
    chk({1'b0, rx_q[0]}, {1'b0, dat[2]});
    report_and_stop();
  end

  initial begin
    repeat (80000) @(posedge core_clk);
    n_fail++;
    report_and_stop();
  end
endmodule : testbench
